// ### core/isasq_defs.svh
// constants for the interleaved converter sequencer
`ifndef ISASQ_DEFS_SVH
`define ISASQ_DEFS_SVH

`define ISASQ_SECTIONS 16
`define ISASQ_SAR_BITS 9
`define ISASQ_CODE_BITS 8
`define ISASQ_CYC_REF_ZERO 4'h0
`define ISASQ_CYC_AUTO_ZERO 4'h1
`define ISASQ_CYC_AUTO_CAL 4'h2
`define ISASQ_CYC_SAMPLE 4'h3
`define ISASQ_CYC_SAR_FIRST 4'h4
`define ISASQ_CYC_SAR_LAST 4'he
`define ISASQ_CYC_TRANSFER 4'hf
`define ISASQ_CODE_FULL 8'hff
`define ISASQ_CLK_PERIOD_NS 10
`define ISASQ_CAL_CYCLES 10000

`endif

// ### core/isasq_pkg.sv
// types for the interleaved converter sequencer
package isasq_pkg;

  typedef logic [3:0] isasq_phase_type;

  typedef enum logic [2:0] {
    isasq_step_ref_zero,
    isasq_step_auto_zero,
    isasq_step_auto_cal,
    isasq_step_sample,
    isasq_step_convert,
    isasq_step_transfer
  } isasq_step_type;

  typedef enum logic {
    isasq_cal_running,
    isasq_cal_done
  } isasq_cal_type;

endpackage : isasq_pkg

// ### core/isasq_sequencer.sv
// sixteen-section interleaved sar sequencer with output multiplexer
`timescale 1ns/1ns
`include "isasq_defs.svh"

// What this block does
// R01: sixteen identical sar sections run side by side against one shared reference scale.
// R02: the sections take turns taking the input so one sample is taken on every clock.
// R03: each section spends exactly sixteen clocks on one conversion.
// R04: frame clocks are reference zero, auto-zero, auto-calibrate, sample, nine-bit sar, transfer.
// R05: sixteen staggered phase signals are derived from the one clock to drive the sections.
// R06: the nine-bit result of the finishing section goes out through a 16-to-1 mux each clock.
// R07: the output word for a sample appears twelve clocks after that sample was taken.
// R08: the driving logic supplies a clock of 2 to 40 MHz with a period of at least 25 ns; the bench drives a 10 ns (100 MHz) clock.
// R09: results leave as eight-bit codes on the parallel data outputs.
// R10: codes are straight binary, all zeros at the bottom and all ones at full scale.
// R11: neighbouring sections are one clock apart and the schedule repeats every sixteen clocks.
// R12: data outputs are registered on the rising edge and released while output disable is high.
// R13: above full scale the overrange flag is set and all eight code bits are held at one.
// R14: calibration takes at least ten thousand clocks after power-up with a running clock.
// R15: a valid strobe marks each clock in which a fresh output word has been presented.
// R16: rotation starts with section thirteen sampling after reset and advances one section per clock.
module isasq_sequencer
  import isasq_pkg::*;
#(
  parameter int sections = `ISASQ_SECTIONS,
  parameter int cal_cycles = `ISASQ_CAL_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // sampled input level from the front end, same clock
  input wire logic [`ISASQ_SAR_BITS-1:0] input_level,
  // output disable pin
  input wire logic output_disable,
  // converted data
  output logic [`ISASQ_CODE_BITS-1:0] conversion_code_bits,
  output logic overrange_flag,
  output logic data_oe_n,
  output logic output_word_valid,
  // timing and status
  output logic [sections-1:0] sample_phase,
  output logic calibrated
);

  isasq_phase_type phase_reg, phase_next;
  logic [`ISASQ_SAR_BITS-1:0] held_reg [sections];
  logic [`ISASQ_SAR_BITS-1:0] held_next [sections];
  logic [`ISASQ_SAR_BITS-1:0] sar_reg [sections];
  logic [`ISASQ_SAR_BITS-1:0] sar_next [sections];
  isasq_step_type step [sections];
  logic [`ISASQ_CODE_BITS-1:0] code_reg, code_next;
  logic ovr_reg, ovr_next;
  logic valid_reg, valid_next;
  logic dis_meta_reg, dis_meta_next;
  logic dis_sync_reg, dis_sync_next;
  logic [13:0] cal_cnt_reg, cal_cnt_next;
  isasq_cal_type cal_reg, cal_next;
  logic cal_flag_reg, cal_flag_next;
  logic [`ISASQ_SAR_BITS-1:0] xfer_chain [sections+1];
  logic [`ISASQ_SAR_BITS-1:0] done_word;

  // last of the nine trials, two correction slots follow it
  localparam isasq_phase_type last_trial = `ISASQ_CYC_SAR_FIRST + 4'(`ISASQ_SAR_BITS - 1);

  // rotation counter
  // wraps every sixteen clocks, so the schedule repeats by itself
  always_comb begin
    phase_next = phase_reg + 4'h1; // R16 R11
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      phase_reg <= 4'h0; // R16
    end else begin
      phase_reg <= phase_next;
    end
  end

  // one section per generate step
  // section s runs s clocks behind section zero
  genvar s;
  generate
    for (s = 0; s < sections; s++) begin : g_sec
      isasq_phase_type cyc;
      logic [3:0] bit_idx;
      logic [`ISASQ_SAR_BITS-1:0] trial;
      assign cyc = phase_reg - 4'(s); // R11 R05
      assign sample_phase[s] = (cyc == `ISASQ_CYC_SAMPLE); // R05 R02
      assign xfer_chain[s+1] = xfer_chain[s] | // R06 R04
        ((step[s] == isasq_step_transfer) ? sar_reg[s] : 9'h000);

      always_comb begin
        // trial bit walks down from the msb, one per frame cycle
        bit_idx = last_trial - cyc;
        trial = sar_reg[s] | (9'h001 << bit_idx);
        held_next[s] = held_reg[s];
        sar_next[s] = sar_reg[s];
        case (cyc) // R04 R03
          `ISASQ_CYC_REF_ZERO: step[s] = isasq_step_ref_zero;
          `ISASQ_CYC_AUTO_ZERO: step[s] = isasq_step_auto_zero;
          `ISASQ_CYC_AUTO_CAL: step[s] = isasq_step_auto_cal;
          `ISASQ_CYC_SAMPLE: step[s] = isasq_step_sample;
          `ISASQ_CYC_TRANSFER: step[s] = isasq_step_transfer;
          default: step[s] = isasq_step_convert;
        endcase
        case (step[s])
          isasq_step_sample: begin
            // level is held for the rest of the frame
            held_next[s] = input_level; // R02
            sar_next[s] = 9'h000;
          end
          isasq_step_convert: begin
            // nine trials at 4..12, two correction slots unused
            if (cyc <= last_trial && trial <= held_reg[s]) begin
              sar_next[s] = trial; // R01 R04
            end
          end
          default: begin
          end
        endcase
      end

      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          // unfed sections hand over zero after reset
          held_reg[s] <= 9'h000;
          sar_reg[s] <= 9'h000;
        end else begin
          held_reg[s] <= held_next[s];
          sar_reg[s] <= sar_next[s];
        end
      end
    end
  endgenerate

  // output multiplexer and code formatting
  // one section is in transfer per clock, so an or of gated words is the 16-to-1 mux
  assign xfer_chain[0] = 9'h000;
  assign done_word = xfer_chain[sections]; // R06

  always_comb begin
    // a fresh word leaves the mux on every clock
    valid_next = 1'b1; // R15
    if (done_word[`ISASQ_SAR_BITS-1]) begin
      // overrange forces every code bit high
      ovr_next = 1'b1; // R13
      code_next = `ISASQ_CODE_FULL; // R13
    end else begin
      ovr_next = 1'b0;
      code_next = done_word[`ISASQ_CODE_BITS-1:0]; // R09 R10
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      code_reg <= 8'h00;
      ovr_reg <= 1'b0;
      valid_reg <= 1'b0;
    end else begin
      code_reg <= code_next; // R12 R07
      ovr_reg <= ovr_next;
      valid_reg <= valid_next; // R15
    end
  end

  // output disable synchroniser
  always_comb begin
    dis_meta_next = output_disable;
    dis_sync_next = dis_meta_reg;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      // pins stay released until the disable level has been seen twice
      dis_meta_reg <= 1'b1;
      dis_sync_reg <= 1'b1;
    end else begin
      dis_meta_reg <= dis_meta_next;
      dis_sync_reg <= dis_sync_next;
    end
  end

  // power-up calibration window
  always_comb begin
    cal_cnt_next = cal_cnt_reg;
    cal_next = cal_reg;
    // the count is 14 bits wide, so cal_cycles must stay at or below 16384
    case (cal_reg)
      isasq_cal_running: begin
        if (cal_cnt_reg >= 14'(cal_cycles - 1)) begin
          cal_next = isasq_cal_done; // R14
        end else begin
          cal_cnt_next = cal_cnt_reg + 14'h0001; // R14
        end
      end
      isasq_cal_done: begin
      end
      default: cal_next = isasq_cal_running;
    endcase
    cal_flag_next = (cal_next == isasq_cal_done); // R14
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cal_cnt_reg <= 14'h0000;
      cal_reg <= isasq_cal_running;
      cal_flag_reg <= 1'b0;
    end else begin
      cal_cnt_reg <= cal_cnt_next;
      cal_reg <= cal_next;
      cal_flag_reg <= cal_flag_next;
    end
  end

  // pin-facing outputs
  assign conversion_code_bits = code_reg;
  assign overrange_flag = ovr_reg;
  assign output_word_valid = valid_reg;
  assign data_oe_n = dis_sync_reg; // R12
  assign calibrated = cal_flag_reg;

endmodule : isasq_sequencer

// ### sim/isasq_properties.sv
// port assertions for the interleaved sequencer
`timescale 1ns/1ns
module isasq_properties #(
  parameter int sections = 16,
  parameter int cal_cycles = 10000
) (
  // watched ports
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [8:0] input_level,
  input wire logic output_disable,
  input wire logic [7:0] conversion_code_bits,
  input wire logic overrange_flag,
  input wire logic data_oe_n,
  input wire logic output_word_valid,
  input wire logic [sections-1:0] sample_phase,
  input wire logic calibrated
);
  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  always_comb cnt_next = (cnt_reg == 5'h1f) ? cnt_reg : cnt_reg + 5'h01;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) cnt_reg <= 5'h00;
    else cnt_reg <= cnt_next;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence s_due;
    cnt_reg >= 5'h0d;
  endsequence
  a_latency_code: assert property (s_due |-> conversion_code_bits ==
    ($past(input_level[7:0], 13) | {8{$past(input_level[8], 13)}})) else $error("late code");
  a_latency_over: assert property (s_due |-> overrange_flag == $past(input_level[8], 13))
    else $error("overrange timing");
  a_over_forces: assert property (overrange_flag |-> conversion_code_bits == 8'hff)
    else $error("overrange code");
  a_phase_rotate: assert property (cnt_reg != 5'h00 |-> sample_phase ==
    (($past(sample_phase) << 1) | ($past(sample_phase) >> 15))) else $error("rotation");
  a_phase_onehot: assert property ($onehot(sample_phase)) else $error("phase not one-hot");
  a_phase_repeat: assert property (cnt_reg >= 5'h10 |-> sample_phase == $past(sample_phase, 16))
    else $error("period");
  a_valid_steady: assert property (cnt_reg != 5'h00 |-> output_word_valid)
    else $error("valid");
  a_oe_follows: assert property (cnt_reg >= 5'h02 |-> data_oe_n == $past(output_disable, 2))
    else $error("output enable");
  a_cal_sticky: assert property (calibrated |=> calibrated) else $error("calibration lost");
endmodule : isasq_properties

bind isasq_sequencer isasq_properties #(.sections(sections), .cal_cycles(cal_cycles))
  isasq_properties_inst (.ref_clk, .nrst, .input_level, .output_disable, .conversion_code_bits,
  .overrange_flag, .data_oe_n, .output_word_valid, .sample_phase, .calibrated);

// ### sim/isasq_host_model.sv
// host model that captures parallel sample words
`timescale 1ns/1ns
module isasq_host_model (
  // from the converter
  input wire logic ref_clk,
  input wire logic [7:0] conversion_code_bits,
  input wire logic overrange_flag,
  input wire logic data_oe_n,
  input wire logic output_word_valid,
  // last captured word
  output logic [8:0] word_seen
);
  // words are taken only while the pins are driven
  always_ff @(posedge ref_clk) begin
    if (output_word_valid && !data_oe_n) word_seen <= {overrange_flag, conversion_code_bits};
  end
endmodule : isasq_host_model

// ### sim/isasq_sequencer_tb_top.sv
// self-checking bench for the interleaved sequencer
`timescale 1ns/1ns
module isasq_sequencer_tb_top;
  logic ref_clk = 1'b0;
  logic nrst;
  logic [8:0] input_level = 9'h000;
  logic output_disable = 1'b0;
  logic [7:0] conversion_code_bits;
  logic overrange_flag, data_oe_n, output_word_valid, calibrated;
  logic [15:0] sample_phase;
  logic [8:0] word_seen;
  int n_mismatch = 0;
  int compares = 0;
  localparam int cal_short = 20;
  initial forever #5 ref_clk = ~ref_clk;
  isasq_sequencer #(.cal_cycles(cal_short)) isasq_sequencer_inst (.ref_clk, .nrst, .input_level,
    .output_disable, .conversion_code_bits, .overrange_flag, .data_oe_n, .output_word_valid,
    .sample_phase, .calibrated);
  isasq_host_model isasq_host_model_inst (.ref_clk, .conversion_code_bits, .overrange_flag,
    .data_oe_n, .output_word_valid, .word_seen);
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  function automatic logic [8:0] lvl(input int i);
    return (i == 3) ? 9'h0ff : (i == 4) ? 9'h100 : 9'(i * 37);
  endfunction : lvl
  function automatic logic [15:0] exp_word(input int i);
    logic [8:0] l;
    l = lvl(i);
    return l[8] ? 16'h01ff : {7'h00, l};
  endfunction : exp_word
  task automatic do_reset();
    @(posedge ref_clk) nrst <= 1'b0;
    repeat (1) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("reset word", 16'h0000,
      {5'h00, output_word_valid, calibrated, overrange_flag, conversion_code_bits});
    chk("reset phase", 16'h2000, sample_phase);
    chk("reset enable", 16'h0001, {15'h0000, data_oe_n});
    @(posedge ref_clk) nrst <= 1'b1;
    $display("reset test done");
  endtask : do_reset
  task automatic t_stream();
    for (int i = 0; i < 40; i++) begin
      @(posedge ref_clk) input_level <= lvl(i);
      @(negedge ref_clk);
      if (i >= 13) chk("code", exp_word(i - 13),
        {7'h00, overrange_flag, conversion_code_bits});
      if (i >= 14) chk("host word", exp_word(i - 14), {7'h00, word_seen});
      chk("valid", 16'h0001, {15'h0000, output_word_valid});
      if (i == cal_short - 2) chk("calibrating", 16'h0000, {15'h0000, calibrated});
      if (i == cal_short - 1) chk("calibrated now", 16'h0001, {15'h0000, calibrated});
    end
    chk("calibrated", 16'h0001, {15'h0000, calibrated});
    $display("stream test done");
  endtask : t_stream
  task automatic t_disable();
    @(posedge ref_clk) output_disable <= 1'b1;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("released", 16'h0001, {15'h0000, data_oe_n});
    @(posedge ref_clk) output_disable <= 1'b0;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("driven", 16'h0000, {15'h0000, data_oe_n});
    $display("disable test done");
  endtask : t_disable
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    nrst <= 1'b0;
    do_reset();
    t_stream();
    t_disable();
    do_reset();
    t_stream();
    tally_and_finish();
  end
endmodule : isasq_sequencer_tb_top
